// ### rtl/rtds_map.svh
`ifndef RTDS_MAP_SVH
`define RTDS_MAP_SVH
// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define RTDS_CLK_PERIOD_NS 4
`define RTDS_TICK_TIME_NS 100000000
`define RTDS_TICK_CYCLES (`RTDS_TICK_TIME_NS / `RTDS_CLK_PERIOD_NS)
`define RTDS_TENTH_MIN_TICKS 16'd60
// ----------------------------------------------------------------------------
// Field values and thresholds
// ----------------------------------------------------------------------------
`define RTDS_FAN_TEMP_C 8'd40
`define RTDS_FAN_ALWAYS 1'b1
`define RTDS_ACTION_STOP 1'b1
`define RTDS_SRC_FIXED 2'h0
`define RTDS_SRC_AI_ONE 2'h1
`define RTDS_SRC_AI_TWO 2'h2
`define RTDS_AI_SHIFT 12
`endif

// ### rtl/rtds_pkg.sv
package rtds_pkg;
  // ----------------------------------------------------------------------------
  // Drive supervisor states, Gray coded along stop, run, dormant, halt.
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RTDS_STOP = 2'h0,
    RTDS_RUN = 2'h1,
    RTDS_DORMANT = 2'h3,
    RTDS_HALT = 2'h2
  } rtds_state_e;
endpackage

// ### rtl/rtds_supervisor.sv
`timescale 1ns/1ps
`include "rtds_map.svh"
// Behaviour
// RQ1: Once the accumulated running time reaches its threshold the running-time-reached output turns on.
// RQ2: After that threshold is reached the drive keeps running when the post-reach action is 0 and stops when it is 1.
// RQ3: In fan mode 0 the fan runs while the drive runs and, while stopped, only when the heatsink is above 40 C; at exactly 40 C the fan keeps its last state.
// RQ4: In fan mode 1 the fan runs all the time from power-on.
// RQ5: While running, a set frequency at or below the sleep frequency for the sleep delay puts the drive dormant.
// RQ6: While dormant with the run command held, a set frequency at or above the wake frequency for the wake delay restarts it.
// RQ7: Sleep and wake are both disabled whenever the sleep and wake frequencies are both zero.
// RQ8: Software should set the wake frequency at or above the sleep frequency and no higher than the maximum frequency.
// RQ9: With the run timer enabled, timing starts at each startup and on expiry the drive stops and the timer-reached output turns on.
// RQ10: The run timer restarts from zero at every startup and its remaining time is shown on a monitor output.
// RQ11: The timer duration comes from the fixed value, analog input one or analog input two, full scale meaning the fixed value.
// RQ12: The fixed timer duration is held in tenths of a minute.
// RQ13: Once the present run has lasted its threshold the present-run-reached output turns on.
// RQ14: With the start guard on, a run command already active at power-on is ignored until it drops and returns.
// RQ15: With the start guard on, a run command active when a fault reset completes is ignored until it drops once.
// RQ16: Software should enable PID operation while stopped when dormancy is used with a PID frequency source.
// RQ17: All time counters and delays advance from one prescaled tick of the system clock.
module rtds_supervisor
  import rtds_pkg::*;
#(
  parameter int TICK_CYCLES = `RTDS_TICK_CYCLES,
  parameter int FW = 16,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run_cmd,
  input wire logic fault_reset_done,
  input wire logic [FW-1:0] set_freq,
  input wire logic [7:0] heatsink_temp,
  input wire logic [15:0] accumulated_run_time,
  input wire logic [15:0] run_time_threshold,
  input wire logic post_reach_action,
  input wire logic fan_mode,
  input wire logic [FW-1:0] sleep_freq,
  input wire logic [15:0] sleep_delay,
  input wire logic [FW-1:0] wake_freq,
  input wire logic [15:0] wake_delay,
  input wire logic run_timer_enable,
  input wire logic [1:0] run_timer_source,
  input wire logic [15:0] run_timer_duration,
  input wire logic [AW-1:0] analog_in_one,
  input wire logic [AW-1:0] analog_in_two,
  input wire logic [15:0] present_run_threshold,
  input wire logic start_guard_enable,
  output logic drive_run,
  output logic dormant,
  output logic fan_on,
  output logic run_time_reached,
  output logic present_run_reached,
  output logic timer_reached,
  output logic [15:0] remaining_time_monitor
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic run_meta;
  logic run_sync;
  logic [1:0] sync_fill;
  logic guard;
  logic cmd_eff;
  logic [31:0] tick_cnt;
  logic tick;
  logic [15:0] sub_cnt;
  logic [15:0] elapsed;
  logic [15:0] delay_cnt;
  logic [15:0] duration;
  logic timer_done;
  logic halt_cond;
  logic sleep_cond;
  logic wake_cond;
  logic dorm_enable;
  logic delay_done;
  rtds_state_e state;
  rtds_state_e next_state;

  // Scales the fixed duration by an analog fraction; adding one extra unit makes full scale exact.
  function automatic logic [15:0] scale_ai(input logic [15:0] dur, input logic [AW-1:0] ai);
    logic [15+AW+1:0] prod;
    prod = (AW+17)'(dur) * (AW+17)'(ai) + (AW+17)'(dur);
    return prod[15+AW:AW];
  endfunction

  // ----------------------------------------------------------------------------
  // Run command synchroniser and start guard
  // ----------------------------------------------------------------------------
  // The terminal is asynchronous to clk, so only the second stage is looked at.
  // The fill flags mark when the second stage holds a sampled pin level instead of its reset value.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_meta <= 1'b0;
      run_sync <= 1'b0;
      sync_fill <= 2'h0;
    end else begin
      run_meta <= run_cmd;
      run_sync <= run_meta;
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  // The guard is armed by reset and by a completed fault reset, and drops only with the command.
  // The reset value of the synchroniser is not a dropped command, so the guard waits until it is filled.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      guard <= 1'b1; // RQ14
    end else if (fault_reset_done) begin
      guard <= 1'b1; // RQ15
    end else if (sync_fill[1] && !run_sync) begin
      guard <= 1'b0; // RQ14
    end
  end

  assign cmd_eff = run_sync && !(guard && start_guard_enable); // RQ14 RQ15

  // ----------------------------------------------------------------------------
  // Prescaler: one 0.1 s tick for every timer in the block
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0; // RQ17
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Present-run elapsed time in tenths of a minute
  // ----------------------------------------------------------------------------
  // Dormant time is not counted; a wakeup counts as a fresh startup.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sub_cnt <= 16'h0;
      elapsed <= 16'h0;
    end else if (state != RTDS_RUN && next_state == RTDS_RUN) begin
      sub_cnt <= 16'h0; // RQ10
      elapsed <= 16'h0; // RQ10
    end else if (state == RTDS_RUN && tick) begin
      if (sub_cnt >= `RTDS_TENTH_MIN_TICKS - 16'h1) begin
        sub_cnt <= 16'h0;
        if (elapsed != 16'hffff) begin
          elapsed <= elapsed + 16'h1; // RQ17
        end
      end else begin
        sub_cnt <= sub_cnt + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Timer duration source and expiry
  // ----------------------------------------------------------------------------
  // The reserved source code falls back to the fixed duration rather than a zero that would stop at once.
  always_comb begin
    unique case (run_timer_source)
      `RTDS_SRC_AI_ONE: duration = scale_ai(run_timer_duration, analog_in_one); // RQ11
      `RTDS_SRC_AI_TWO: duration = scale_ai(run_timer_duration, analog_in_two); // RQ11
      default: duration = run_timer_duration; // RQ11 RQ12
    endcase
  end

  assign timer_done = run_timer_enable && (elapsed >= duration); // RQ9
  assign halt_cond = timer_done || (run_time_reached && post_reach_action == `RTDS_ACTION_STOP); // RQ2 RQ9

  // ----------------------------------------------------------------------------
  // Sleep and wake qualification
  // ----------------------------------------------------------------------------
  assign dorm_enable = (sleep_freq != '0) || (wake_freq != '0); // RQ7
  assign sleep_cond = dorm_enable && state == RTDS_RUN && set_freq <= sleep_freq; // RQ5
  assign wake_cond = dorm_enable && state == RTDS_DORMANT && set_freq >= wake_freq; // RQ6
  // The first tick after the condition arises ends only a part period, so one tick more than the delay is
  // counted; this keeps the wait at least as long as asked, while a zero delay still acts at once.
  assign delay_done = sleep_cond ? (sleep_delay == 16'h0 || delay_cnt > sleep_delay) :
                                   (wake_delay == 16'h0 || delay_cnt > wake_delay); // RQ5 RQ6

  // One delay counter serves both directions, since only one of them can be pending.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      delay_cnt <= 16'h0;
    end else if (!(sleep_cond || wake_cond) || state != next_state) begin
      delay_cnt <= 16'h0;
    end else if (tick && delay_cnt != 16'hffff) begin
      delay_cnt <= delay_cnt + 16'h1; // RQ5 RQ6
    end
  end

  // ----------------------------------------------------------------------------
  // Run state machine
  // ----------------------------------------------------------------------------
  // Loss of the command wins over every other exit so a stop request is never delayed.
  always_comb begin
    next_state = state;
    unique case (state)
      RTDS_STOP: begin
        if (cmd_eff) begin
          next_state = RTDS_RUN;
        end
      end
      RTDS_RUN: begin
        if (!cmd_eff) begin
          next_state = RTDS_STOP;
        end else if (halt_cond) begin
          next_state = RTDS_HALT; // RQ2 RQ9
        end else if (sleep_cond && delay_done) begin
          next_state = RTDS_DORMANT; // RQ5
        end
      end
      RTDS_DORMANT: begin
        if (!cmd_eff) begin
          next_state = RTDS_STOP;
        end else if (wake_cond && delay_done) begin
          next_state = RTDS_RUN; // RQ6
        end
      end
      RTDS_HALT: begin
        if (!cmd_eff) begin
          next_state = RTDS_STOP;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= RTDS_STOP;
      drive_run <= 1'b0;
      dormant <= 1'b0;
    end else begin
      state <= next_state;
      drive_run <= next_state == RTDS_RUN;
      dormant <= next_state == RTDS_DORMANT;
    end
  end

  // ----------------------------------------------------------------------------
  // Output flags and monitor
  // ----------------------------------------------------------------------------
  // The timer flag stands from expiry until the next startup.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timer_reached <= 1'b0;
    end else if (state == RTDS_RUN && next_state == RTDS_HALT && timer_done) begin
      timer_reached <= 1'b1; // RQ9
    end else if (state != RTDS_RUN && next_state == RTDS_RUN) begin
      timer_reached <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_time_reached <= 1'b0;
      present_run_reached <= 1'b0;
      remaining_time_monitor <= 16'h0;
    end else begin
      run_time_reached <= accumulated_run_time >= run_time_threshold; // RQ1
      present_run_reached <= state == RTDS_RUN && elapsed >= present_run_threshold; // RQ13
      remaining_time_monitor <= (elapsed >= duration) ? 16'h0 : duration - elapsed; // RQ10
    end
  end

  // At exactly 40 C the fan keeps its last state, which avoids chatter on a noisy sensor.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fan_on <= 1'b0;
    end else if (fan_mode == `RTDS_FAN_ALWAYS) begin
      fan_on <= 1'b1; // RQ4
    end else if (next_state == RTDS_RUN || heatsink_temp > `RTDS_FAN_TEMP_C) begin
      fan_on <= 1'b1; // RQ3
    end else if (heatsink_temp < `RTDS_FAN_TEMP_C) begin
      fan_on <= 1'b0; // RQ3
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  property p_run_time_flag;
    @(posedge clk) disable iff (!resetn)
    (accumulated_run_time >= run_time_threshold) |=> run_time_reached;
  endproperty
  a_run_time_flag: assert property (p_run_time_flag) else $error("run time flag missing"); // RQ1

  property p_post_reach_stop;
    @(posedge clk) disable iff (!resetn)
    (state == RTDS_RUN && run_time_reached && post_reach_action && cmd_eff) |=> !drive_run ##1 !drive_run;
  endproperty
  a_post_reach_stop: assert property (p_post_reach_stop) else $error("drive not stopped"); // RQ2

  property p_fan_run;
    @(posedge clk) disable iff (!resetn)
    (fan_mode == 1'b0 && drive_run) |-> fan_on;
  endproperty
  a_fan_run: assert property (p_fan_run) else $error("fan off while running"); // RQ3

  property p_fan_always;
    @(posedge clk) disable iff (!resetn)
    fan_mode[*2] |-> fan_on;
  endproperty
  a_fan_always: assert property (p_fan_always) else $error("fan off in mode one"); // RQ4

  property p_no_dormant;
    @(posedge clk) disable iff (!resetn)
    (sleep_freq == '0 && wake_freq == '0 && state == RTDS_RUN) |=> !dormant;
  endproperty
  a_no_dormant: assert property (p_no_dormant) else $error("dormant while disabled"); // RQ7

  property p_guard_hold;
    @(posedge clk) disable iff (!resetn)
    (guard && start_guard_enable && state == RTDS_STOP && !fault_reset_done) |=> !drive_run;
  endproperty
  a_guard_hold: assert property (p_guard_hold) else $error("guarded command started drive"); // RQ14

  property p_fault_guard;
    @(posedge clk) disable iff (!resetn)
    fault_reset_done |=> guard;
  endproperty
  a_fault_guard: assert property (p_fault_guard) else $error("guard not armed"); // RQ15

  property p_timer_stop;
    @(posedge clk) disable iff (!resetn)
    (state == RTDS_RUN && timer_done && cmd_eff) |=> (timer_reached && !drive_run);
  endproperty
  a_timer_stop: assert property (p_timer_stop) else $error("timer expiry ignored"); // RQ9

  property p_timer_restart;
    @(posedge clk) disable iff (!resetn)
    $rose(drive_run) |-> (elapsed == 16'h0 && !timer_reached);
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted"); // RQ10

endmodule // rtds_supervisor

// ### verif/rtds_drive_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Run control core model: keeps the accumulated running time outside the block
// ----------------------------------------------------------------------------
module rtds_drive_model #(
  parameter int TICK = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic drive_run,
  output logic [15:0] accumulated_run_time
);
  int unsigned presc;
  // One scaled hour passes every TICK running clocks, so thresholds are reached in tens of cycles.
  // The total survives stops and is only cleared by reset, as a power-on counter would be.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      presc <= 0;
      accumulated_run_time <= 16'h0000;
    end else if (drive_run) begin
      presc <= (presc == TICK - 1) ? 0 : presc + 1;
      if (presc == TICK - 1) begin
        accumulated_run_time <= accumulated_run_time + 16'h0001;
      end
    end
  end
endmodule // rtds_drive_model

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rtds_pkg::*;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic run_cmd = 1'b1;
  logic fault_reset_done = 1'b0;
  logic [15:0] set_freq = 16'h01f4;
  logic [7:0] heatsink_temp = 8'h1e;
  logic [15:0] run_time_threshold = 16'hffff;
  logic post_reach_action = 1'b0;
  logic fan_mode = 1'b0;
  logic [15:0] sleep_freq = 16'h0064;
  logic [15:0] sleep_delay = 16'h0002;
  logic [15:0] wake_freq = 16'h00c8;
  logic [15:0] wake_delay = 16'h0002;
  logic run_timer_enable = 1'b0;
  logic [1:0] run_timer_source = 2'h0;
  logic [15:0] run_timer_duration = 16'h0002;
  logic [11:0] analog_in_one = 12'hfff;
  logic [11:0] analog_in_two = 12'h800;
  logic [15:0] present_run_threshold = 16'hffff;
  logic start_guard_enable = 1'b1;
  logic drive_run, dormant, fan_on, run_time_reached, present_run_reached, timer_reached;
  logic [15:0] remaining_time_monitor, accumulated_run_time;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  rtds_supervisor #(.TICK_CYCLES(TK)) dut_u (.clk(clk), .resetn(resetn), .run_cmd(run_cmd),
    .fault_reset_done(fault_reset_done), .set_freq(set_freq), .heatsink_temp(heatsink_temp),
    .accumulated_run_time(accumulated_run_time), .run_time_threshold(run_time_threshold),
    .post_reach_action(post_reach_action), .fan_mode(fan_mode), .sleep_freq(sleep_freq),
    .sleep_delay(sleep_delay), .wake_freq(wake_freq), .wake_delay(wake_delay),
    .run_timer_enable(run_timer_enable), .run_timer_source(run_timer_source),
    .run_timer_duration(run_timer_duration), .analog_in_one(analog_in_one), .analog_in_two(analog_in_two),
    .present_run_threshold(present_run_threshold), .start_guard_enable(start_guard_enable),
    .drive_run(drive_run), .dormant(dormant), .fan_on(fan_on), .run_time_reached(run_time_reached),
    .present_run_reached(present_run_reached), .timer_reached(timer_reached),
    .remaining_time_monitor(remaining_time_monitor));
  rtds_drive_model #(.TICK(TK)) model_u (.clk(clk), .resetn(resetn), .drive_run(drive_run),
    .accumulated_run_time(accumulated_run_time));
  // ----------------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end
  // A hang anywhere is cut off well past the few thousand cycles the tests need.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_drive(input logic exp, input int lim, output int k);
    k = 0;
    while (drive_run !== exp && k < lim) begin
      step(1);
      k++;
    end
  endtask
  // Inputs change one step after the edge, so a restart drops the command long enough to pass the sync.
  task automatic restart();
    run_cmd = 1'b0;
    step(5);
    run_cmd = 1'b1;
    wait_drive(1'b1, 10, n);
    chk("start_latency", 16'd3, 16'(n));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_guard();
    step(20);
    chk("guarded_run", 16'd0, 16'(drive_run));
    restart();
    $display("test guard done");
  endtask
  task automatic t_fan();
    run_cmd = 1'b0;
    heatsink_temp = 8'h32;
    step(6);
    chk("fan_hot_stop", 16'd1, 16'(fan_on));
    heatsink_temp = 8'h1e;
    step(3);
    chk("fan_cool_stop", 16'd0, 16'(fan_on));
    restart();
    chk("fan_running", 16'd1, 16'(fan_on));
    fan_mode = 1'b1;
    run_cmd = 1'b0;
    step(6);
    chk("fan_always", 16'd1, 16'(fan_on));
    fan_mode = 1'b0;
    restart();
    $display("test fan done");
  endtask
  task automatic t_sleep();
    set_freq = 16'h0064; // Exactly the sleep frequency still counts as low.
    wait_drive(1'b0, 40, n);
    chk("sleep_entry", 16'd1, 16'(dormant));
    chk("sleep_wait", 16'd1, 16'(n >= 8 && n < 30));
    // The frequency source keeps updating while the drive is dormant, as a source run in stop would.
    set_freq = 16'h00c8;
    wait_drive(1'b1, 40, n);
    chk("wake_exit", 16'd0, 16'(dormant));
    chk("wake_wait", 16'd1, 16'(n >= 8 && n < 30));
    sleep_freq = 16'h0000;
    wake_freq = 16'h0000;
    set_freq = 16'h0000;
    step(60);
    chk("sleep_off", 16'd1, 16'(drive_run & ~dormant));
    set_freq = 16'h01f4;
    $display("test sleep done");
  endtask
  task automatic t_present();
    present_run_threshold = 16'h0001;
    restart();
    step(200);
    chk("present_early", 16'd0, 16'(present_run_reached));
    step(60);
    chk("present_hit", 16'd1, 16'(present_run_reached));
    present_run_threshold = 16'hffff;
    $display("test present done");
  endtask
  task automatic t_run_time();
    run_time_threshold = accumulated_run_time + 16'h0004;
    step(1);
    chk("run_time_early", 16'd0, 16'(run_time_reached));
    step(30);
    chk("run_time_hit", 16'd1, 16'(run_time_reached));
    chk("run_continue", 16'd1, 16'(drive_run));
    // The registered flag must fall before the stop action is armed, or the stale flag would stop the drive.
    run_time_threshold = accumulated_run_time + 16'h0003;
    step(2);
    chk("run_time_clear", 16'd0, 16'(run_time_reached));
    post_reach_action = 1'b1;
    wait_drive(1'b0, 40, n);
    chk("run_stop", 16'd1, 16'(run_time_reached & ~drive_run));
    run_time_threshold = 16'hffff;
    post_reach_action = 1'b0;
    restart();
    $display("test run time done");
  endtask
  task automatic t_timer();
    logic [15:0] dur [4];
    dur = '{16'h0002, 16'h0002, 16'h0004, 16'h0002}; // Analog two at half scale halves 4 to 2.
    run_timer_enable = 1'b1;
    for (int s = 0; s < 4; s++) begin
      run_timer_source = 2'(s);
      run_timer_duration = dur[s];
      restart();
      step(2);
      chk("timer_cleared", 16'd0, 16'(timer_reached));
      chk("remaining_start", 16'h0002, remaining_time_monitor);
      wait_drive(1'b0, 700, n);
      chk("timer_length", 16'd1, 16'(n >= 460 && n <= 500));
      chk("timer_flag", 16'd1, 16'(timer_reached));
      chk("remaining_end", 16'h0000, remaining_time_monitor);
    end
    $display("test timer done");
  endtask
  task automatic t_fault();
    // The command returns while stopped and a fault reset completes before it can start the drive.
    run_timer_enable = 1'b0;
    run_cmd = 1'b0;
    step(5);
    run_cmd = 1'b1;
    step(1);
    fault_reset_done = 1'b1;
    step(1);
    fault_reset_done = 1'b0;
    step(10);
    chk("fault_held", 16'd0, 16'(drive_run));
    restart();
    $display("test fault done");
  endtask
  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    step(12);
    resetn = 1'b1;
    t_guard();
    t_fan();
    t_sleep();
    t_present();
    t_run_time();
    t_timer();
    t_fault();
    finish_test();
  end
endmodule // testbench
